// >>> inc/mwd_pkg.sv
// package of constants and types for the millisecond watchdog
package mwd_pkg;
  // ---------------------------------------------------------------
  // register map (printed offsets are indexes, byte address = 4x)
  // ---------------------------------------------------------------
  localparam logic [7:0] MWD_IDX_TIMEOUT_CTRL = 8'hd6;
  localparam logic [7:0] MWD_IDX_OFF_KEY = 8'hd7;
  localparam logic [7:0] MWD_IDX_CLK_FREQ = 8'h51;
  localparam logic [9:0] MWD_ADR_TIMEOUT_CTRL = {MWD_IDX_TIMEOUT_CTRL, 2'b00};
  localparam logic [9:0] MWD_ADR_OFF_KEY = {MWD_IDX_OFF_KEY, 2'b00};
  localparam logic [9:0] MWD_ADR_CLK_FREQ = {MWD_IDX_CLK_FREQ, 2'b00};

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MWD_LIMIT_LSB = 0;
  localparam int MWD_COUNT_LSB = 16;
  localparam logic [15:0] MWD_LIMIT_RST = 16'h03e8;
  localparam logic [15:0] MWD_COUNT_RST = 16'h0000;
  localparam logic [31:0] MWD_OFF_KEY = 32'h0d15ab1e;
  localparam logic [31:0] MWD_ON_VALUE = 32'h00000000;
  localparam logic [6:0] MWD_FREQ_RST = 7'h19;
  localparam logic [6:0] MWD_FREQ_MIN = 7'h05;
  localparam logic [6:0] MWD_FREQ_MAX = 7'h64;

  // ---------------------------------------------------------------
  // timing: one tick per millisecond, 1000 us each
  // ---------------------------------------------------------------
  localparam int MWD_TICK_US = 1000;
  localparam int MWD_CLK_MHZ = 10;
  localparam int MWD_TICK_CYC = MWD_TICK_US * MWD_CLK_MHZ;

  typedef struct packed {
    logic [9:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } mwd_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic err;
  } mwd_wb_rsp_t;
endpackage

// >>> sim/mwd_top_props.sv
// port assertions for the millisecond watchdog
`timescale 1ns/100ps
module mwd_props
  import mwd_pkg::*;
#(parameter int TICK_US = MWD_TICK_US) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [9:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic wb_we_i, // write
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic wb_err_o, // error
  input wire logic running_power_state_i, // running_power_state
  input wire logic tile_reset_o, // tile reset
  input wire logic wdog_enabled_o // armed
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // first cycle of a request only; the answer cycle is excluded
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire wr = req & wb_we_i & (wb_sel_i == 4'hf);
  wire wr_tc = wr & (wb_adr_i == MWD_ADR_TIMEOUT_CTRL);
  wire wr_ky = wr & (wb_adr_i == MWD_ADR_OFF_KEY);
  wire cpl = (wb_dat_i[31:16] == ~wb_dat_i[15:0]);
  property p_answer; req |=> wb_ack_o | wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_pulse; wb_ack_o |=> !wb_ack_o && !wb_err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_bad; wr_tc && !cpl |=> wb_err_o && !wb_ack_o; endproperty
  a_bad: assert property (p_bad) else $error("bad word taken");
  property p_good; wr_tc && cpl |=> wb_ack_o && !wb_err_o; endproperty
  a_good: assert property (p_good) else $error("good word refused");
  property p_off; wr_ky && wb_dat_i == MWD_OFF_KEY |-> ##2 !wdog_enabled_o;
  endproperty
  a_off: assert property (p_off) else $error("key kept armed");
  property p_on; wr_ky && wb_dat_i == MWD_ON_VALUE |-> ##2 wdog_enabled_o;
  endproperty
  a_on: assert property (p_on) else $error("zero not armed");
  property p_quiet;
    !wdog_enabled_o || !running_power_state_i |=> !tile_reset_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset while idle");
  property p_single; tile_reset_o |=> !tile_reset_o; endproperty
  a_single: assert property (p_single) else $error("reset held");
  c_err: cover property (wr_tc ##1 wb_err_o);
  c_on: cover property (wr_ky ##2 wdog_enabled_o);
  c_rst: cover property (tile_reset_o);
endmodule
bind mwd_top mwd_props #(.TICK_US(TICK_US)) mwd_props_inst (.clk_i(clk_i),
  .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .running_power_state_i(running_power_state_i),
  .tile_reset_o(tile_reset_o), .wdog_enabled_o(wdog_enabled_o));

// >>> sim/test_mwd_top.sv
// self-checking bench for the millisecond watchdog
`timescale 1ns/100ps
module test_mwd_top;
  import mwd_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [9:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, r;
  logic [3:0] wb_sel_i = 4'hf;
  logic running_power_state_i = 0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, tile_reset_o, wdog_enabled_o;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [15:0] lim;
  int err_total = 0, total_checks = 0, n_rst = 0, cyc = 0;
  // tick = 5 MHz * 2 = 10 clocks once frequency is set to 5
  mwd_top #(.TICK_US(2)) mwd_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .running_power_state_i(running_power_state_i),
    .tile_reset_o(tile_reset_o), .wdog_enabled_o(wdog_enabled_o));
  always #50 clk_i = ~clk_i;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // x = {err, read data}; read data compared on reads only
  task automatic bus(input logic [9:0] a, input logic [31:0] d,
                     input logic w, input logic [32:0] x);
    q.push_back({w, x});
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic chk(input logic c);
    total_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t state", $time);
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (tile_reset_o === 1'b1) n_rst++;
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      e = q.pop_front();
      total_checks++;
      if (wb_err_o !== e[32] || (!e[33] && wb_dat_o !== e[31:0])) begin
        err_total++;
        $display("CHECK FAILED %0t bus answer", $time);
      end
    end
    if (cyc == 3000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    r = $urandom(23);
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(MWD_ADR_TIMEOUT_CTRL, 0, 0, {1'b0, 32'h3e8});
    bus(MWD_ADR_OFF_KEY, 0, 0, {1'b0, MWD_OFF_KEY});
    chk(wdog_enabled_o === 1'b0);
    $display("reset values done");
    r = $urandom;
    bus(MWD_ADR_TIMEOUT_CTRL, {~r[15:0] ^ 16'h0010, r[15:0]}, 1,
        {1'b1, 32'h0});
    bus(10'h000, r, 1, {1'b1, 32'h0});
    bus(MWD_ADR_CLK_FREQ, 32'd101, 1, {1'b1, 32'h0});
    bus(MWD_ADR_TIMEOUT_CTRL, 0, 0, {1'b0, 32'h3e8});
    $display("refusals done");
    bus(MWD_ADR_CLK_FREQ, 32'd5, 1, '0);
    bus(MWD_ADR_TIMEOUT_CTRL, {~16'd4, 16'd4}, 1, '0);
    bus(MWD_ADR_TIMEOUT_CTRL, 0, 0, {1'b0, 32'h00040004});
    bus(MWD_ADR_OFF_KEY, MWD_ON_VALUE, 1, '0);
    @(posedge clk_i);
    chk(wdog_enabled_o === 1'b1);
    repeat (100) @(posedge clk_i);
    chk(n_rst == 0);
    running_power_state_i <= 1;
    repeat (45) @(posedge clk_i);
    chk(n_rst == 1);
    $display("expiry done");
    lim = 16'd6 + 16'($urandom % 4);
    repeat (6) begin
      bus(MWD_ADR_TIMEOUT_CTRL, {~lim, lim}, 1, '0);
      repeat (25) @(posedge clk_i);
    end
    chk(n_rst == 1);
    $display("kick done");
    bus(MWD_ADR_OFF_KEY, MWD_OFF_KEY, 1, '0);
    bus(MWD_ADR_TIMEOUT_CTRL, 0, 0, {1'b0, 16'h0, lim});
    repeat (150) @(posedge clk_i);
    chk(n_rst == 1);
    $display("disable done");
    finish_test;
  end
endmodule

// >>> verilog/mwd_tick_gen.sv
// millisecond tick divider driven by the programmed clock frequency
`timescale 1ns/100ps
module mwd_tick_gen
  import mwd_pkg::*;
#(
  parameter int TICK_US = MWD_TICK_US
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [6:0] freq_mhz_i, // clock frequency in MHz
  output logic tick_o // one-cycle pulse each millisecond
);
  // ms counter is 10 bits wide, so the tick length must fit in it
  if (TICK_US < 1 || TICK_US > 1000) begin : g_bad_tick
    $error("bad TICK_US");
  end

  // ---------------------------------------------------------------
  // two-stage divide: microsecond prescaler, then microsecond count
  // ---------------------------------------------------------------
  logic [6:0] us_cnt;
  logic [9:0] ms_cnt;
  wire us_end = (us_cnt >= freq_mhz_i - 7'h01);
  wire ms_end = (ms_cnt >= 10'(TICK_US - 1));
  // a frequency change mid-count only shortens or stretches one tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      us_cnt <= 7'h00;
      ms_cnt <= 10'h000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      us_cnt <= us_end ? 7'h00 : us_cnt + 7'h01;
      if (us_end) begin
        ms_cnt <= ms_end ? 10'h000 : ms_cnt + 10'h001;
        tick_o <= ms_end;
      end
    end
  end
endmodule

// >>> verilog/mwd_top.sv
// millisecond watchdog with a classic wishbone register slave
`timescale 1ns/100ps
module mwd_top
  import mwd_pkg::*;
#(
  parameter int TICK_US = MWD_TICK_US
) (
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [9:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic wb_we_i, // write enable
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o, // negative acknowledge
  input wire logic running_power_state_i, // high while running_power_state
  output logic tile_reset_o, // one-cycle tile reset pulse
  output logic wdog_enabled_o // watchdog armed
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MWD_IDLE = 2'b01,
    MWD_DONE = 2'b10
  } mwd_bus_t;

  mwd_bus_t bus_st;
  mwd_wb_req_t req;
  logic [15:0] limit;
  logic [15:0] count;
  logic [31:0] off_key;
  logic [6:0] freq_mhz;
  logic tick;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_err;

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
                 we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};

  function automatic logic cmpl_ok(input logic [31:0] d);
    cmpl_ok = (d[31:16] == ~d[15:0]);
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire req_new = req.cyc && req.stb && (bus_st == MWD_IDLE);
  wire hit_to = (req.adr == MWD_ADR_TIMEOUT_CTRL);
  wire hit_key = (req.adr == MWD_ADR_OFF_KEY);
  wire hit_frq = (req.adr == MWD_ADR_CLK_FREQ);
  wire full_word = (req.sel == 4'hf);
  wire wr = req_new && req.we;
  // partial writes are refused; the checks span the whole word
  wire to_ok = full_word && cmpl_ok(req.dat);
  wire freq_ok = full_word && req.dat[31:7] == 25'h0000000 &&
                 req.dat[6:0] >= MWD_FREQ_MIN &&
                 req.dat[6:0] <= MWD_FREQ_MAX;
  wire key_ok = full_word;
  wire kick = wr && hit_to && to_ok;
  wire key_wr = wr && hit_key && key_ok;
  wire frq_wr = wr && hit_frq && freq_ok;
  wire is_off = (off_key == MWD_OFF_KEY);
  wire armed = !is_off;
  wire dis_now = key_wr && (req.dat == MWD_OFF_KEY);
  wire run = armed && running_power_state_i;
  wire expire = run && tick && (count == 16'h0001 || count == 16'h0000);

  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_to) begin
      next_rdata = {count, limit};
    end else if (hit_key) begin
      next_rdata = off_key;
    end else if (hit_frq) begin
      next_rdata = {25'h0000000, freq_mhz};
    end
  end

  always_comb begin
    next_ack = 1'b0;
    next_err = 1'b0;
    if (req_new) begin
      if (!(hit_to || hit_key || hit_frq)) begin
        next_err = 1'b1;
      end else if (req.we) begin
        next_ack = hit_to ? to_ok : (hit_key ? key_ok : freq_ok);
        next_err = !next_ack;
      end else begin
        next_ack = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus slave: one-cycle latency, ack dropped the next cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st <= MWD_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      if (req_new) begin
        wb_dat_o <= req.we ? 32'h00000000 : next_rdata;
      end
      unique case (bus_st)
        MWD_IDLE: bus_st <= req_new ? MWD_DONE : MWD_IDLE;
        MWD_DONE: bus_st <= MWD_IDLE;
        default: bus_st <= MWD_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit <= MWD_LIMIT_RST;
      off_key <= MWD_OFF_KEY;
      freq_mhz <= MWD_FREQ_RST;
    end else begin
      if (kick) begin
        limit <= req.dat[15:0];
      end
      if (key_wr) begin
        off_key <= req.dat;
      end
      if (frq_wr) begin
        freq_mhz <= req.dat[6:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // countdown
  // ---------------------------------------------------------------
  // a kick wins over a tick in the same cycle so the restart is exact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= MWD_COUNT_RST;
      tile_reset_o <= 1'b0;
    end else begin
      tile_reset_o <= expire;
      if (dis_now) begin
        count <= 16'h0000;
      end else if (kick) begin
        count <= req.dat[15:0];
      end else if (key_wr && is_off && req.dat != MWD_OFF_KEY) begin
        count <= limit;
      end else if (expire) begin
        count <= limit;
      end else if (run && tick) begin
        count <= count - 16'h0001;
      end
    end
  end

  assign wdog_enabled_o = armed;

  mwd_tick_gen #(
    .TICK_US(TICK_US)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .freq_mhz_i(freq_mhz),
    .tick_o(tick)
  );
endmodule
